// ---- verilog/lvrc_pkg.sv ----
// Shared constants and types of the range configuration loader.
package lvrc_pkg;

  // Geometry of the range configuration word.
  localparam int unsigned LVRC_CHANS = 8;
  localparam int unsigned LVRC_CODE_W = 3;
  localparam int unsigned LVRC_WORD_W = 24;

  // Serial clock cycles, one bit per edge, that carry one word.
  localparam logic [3:0] LVRC_PAIRS_PER_WORD = 4'hC;
  localparam logic [3:0] LVRC_PAIR_LAST = 4'hB;
  localparam logic [3:0] LVRC_PAIR_ZERO = 4'h0;
  localparam logic [3:0] LVRC_PAIR_ONE = 4'h1;

  // Reset value: every channel in range code 7.
  localparam logic [23:0] LVRC_CFG_RESET = 24'hFFFFFF;
  localparam logic [23:0] LVRC_WORD_ZERO = 24'h000000;
  localparam logic [2:0] LVRC_CODE_OFF = 3'h0;
  localparam logic [7:0] LVRC_EN_RESET = 8'hFF;
  localparam logic [3:0] LVRC_CNT_RESET = 4'h8;

  // Start-up delay before the first window opens.
  localparam int unsigned LVRC_STARTUP_MS = 10;
  localparam int unsigned LVRC_CLK_KHZ = 250000;
  localparam int unsigned LVRC_STARTUP_CYC = LVRC_STARTUP_MS * LVRC_CLK_KHZ;
  localparam logic [21:0] LVRC_TMR_ZERO = 22'h000000;
  localparam logic [21:0] LVRC_TMR_ONE = 22'h000001;

  // One channel's range code and the whole register, channel i at [3i+2:3i].
  typedef logic [2:0] lvrc_code_t;
  typedef struct packed {
    lvrc_code_t [7:0] code;
  } lvrc_cfg_s;

  // Window sequencer states.
  typedef enum logic [1:0] {
    LVRC_ST_BOOT = 2'b00,
    LVRC_ST_CLOSED = 2'b01,
    LVRC_ST_OPEN = 2'b10
  } lvrc_state_e;

endpackage : lvrc_pkg

// ---- verilog/lvrc_link_rx.sv ----
// Link-side DDR receiver that assembles 24-bit configuration words.
`timescale 1ns/10ps
module lvrc_link_rx (
  // Link clock, asynchronous reset and partial-word clear
  input wire logic clk_link,
  input wire logic rst_n,
  input wire logic clr_n,
  // Serial data
  input wire logic config_serial_in,
  // Completed word and its toggle
  output lvrc_pkg::lvrc_cfg_s word,
  output logic word_tgl
);

  logic rise_bit_r;
  logic [21:0] shift_r;
  logic [3:0] pair_r;
  logic [23:0] full_w;
  logic frame_clr_n;

  // A clear drops a partial word but never the toggle, so no false event.
  assign frame_clr_n = rst_n & clr_n; // [RULE7] [RULE16]

  // The bit of the rising edge, then the bit of the falling edge, MSB first.
  assign full_w = {shift_r, rise_bit_r, config_serial_in}; // [RULE13] [RULE16]

  // Rising edge captures the first bit of each clock cycle.
  always_ff @(posedge clk_link or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      rise_bit_r <= 1'b0;
    end else begin
      rise_bit_r <= config_serial_in; // [RULE13]
    end
  end

  // Falling edge shifts a bit pair in and counts the pairs of a word.
  always_ff @(negedge clk_link or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      shift_r <= 22'h000000;
      pair_r <= lvrc_pkg::LVRC_PAIR_ZERO;
    end else begin
      shift_r <= full_w[21:0];
      if (pair_r == lvrc_pkg::LVRC_PAIR_LAST) begin
        pair_r <= lvrc_pkg::LVRC_PAIR_ZERO; // [RULE10]
      end else begin
        pair_r <= pair_r + lvrc_pkg::LVRC_PAIR_ONE; // [RULE7]
      end
    end
  end

  // The 12th falling edge closes a word; only reset clears word and toggle.
  always_ff @(negedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      word <= '0;
      word_tgl <= 1'b0;
    end else if (pair_r == lvrc_pkg::LVRC_PAIR_LAST) begin
      word <= full_w; // [RULE11]
      word_tgl <= ~word_tgl;
    end
  end

endmodule : lvrc_link_rx

// ---- verilog/lvrc_evt_sync.sv ----
// Three-stage toggle synchroniser that yields a one-cycle event.
`timescale 1ns/10ps
module lvrc_evt_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Toggle from the other domain and the resulting pulse
  input wire logic tgl_in,
  output logic evt
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic seen_r;

  // A change counts once the second and third stages agree.
  assign evt = (s2_r == s3_r) && (s3_r != seen_r);

  // Synchroniser chain and the last accepted level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      s1_r <= tgl_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (evt) begin
        seen_r <= s3_r;
      end
    end
  end

endmodule : lvrc_evt_sync

// ---- verilog/lvrc_loader.sv ----
// Range configuration loader: windows, word acceptance and the register.
//
// Behaviour
// RULE1: Hold one 24-bit range register, 3-bit code per channel.
// RULE2: Reset sets the register to all ones, range code 7 everywhere.
// RULE3: Accept configuration words only while a transaction window is open.
// RULE4: A new setting drives the next conversion at once, no settling delay.
// RULE5: Code 000 disables a channel at once and shortens the next conversion.
// RULE6: Re-enabling a channel needs no extra settling before conversion.
// RULE7: Fewer than 24 edges in a window leave the register unchanged.
// RULE8: Exactly 24 edges load the received word into the register.
// RULE9: An all-zero word does not change the register.
// RULE10: Every complete word in a window applies; trailing partial is dropped.
// RULE11: Word sent DDR over 12 cycles; loads after the 12th falling edge.
// RULE12: Host holds data low to keep the current settings.
// RULE13: Data sampled on both rising and falling serial clock edges.
// RULE14: Windows open 10 ms after reset and at each busy falling edge.
// RULE15: Bus active only with select low; serial clock idles low.
// RULE16: Word MSB first, channel i at bits [3i+2:3i]; count restarts per window.
// RULE17: Host finishes transfers before the next conversion starts.
`timescale 1ns/10ps
module lvrc_loader #(
  parameter int unsigned STARTUP_CYCLES = lvrc_pkg::LVRC_STARTUP_CYC
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Serial link from the host
  input wire logic HOST_SERIAL_CLOCK,
  input wire logic CONFIG_SERIAL_IN,
  input wire logic SELECT_N,
  // Conversion core status
  input wire logic CONV_BUSY,
  // Range settings for the conversion core
  output lvrc_pkg::lvrc_cfg_s RANGE_CFG,
  output logic [7:0] CHAN_EN,
  output logic [3:0] CHAN_COUNT,
  // Loader status
  output logic WINDOW_OPEN,
  output logic CFG_LOADED,
  output logic WORD_KEPT,
  output logic WORD_REFUSED
);

  lvrc_pkg::lvrc_state_e state_r;
  lvrc_pkg::lvrc_state_e state_nxt;
  logic [21:0] tmr_r;
  logic busy_q_r;
  logic link_clr_n_r;
  logic link_clr_n;
  logic word_tgl;
  logic word_evt;
  lvrc_pkg::lvrc_cfg_s link_word;
  lvrc_pkg::lvrc_cfg_s cfg_nxt;
  logic busy_fall;
  logic busy_rise;
  logic tmr_done;
  logic opening;
  logic in_window;
  logic word_zero;
  logic take_word;

  // Channel enables: a channel runs unless its code is 000.
  function automatic logic [7:0] chan_enables(input lvrc_pkg::lvrc_cfg_s c);
    logic [7:0] en;
    en = 8'h00;
    for (int i = 0; i < lvrc_pkg::LVRC_CHANS; i++) begin
      en[i] = (c.code[i] != lvrc_pkg::LVRC_CODE_OFF); // [RULE5] [RULE6]
    end
    return en;
  endfunction : chan_enables

  // Number of enabled channels, which sets the conversion length.
  function automatic logic [3:0] chan_count(input lvrc_pkg::lvrc_cfg_s c);
    logic [7:0] en;
    logic [3:0] n;
    en = chan_enables(c);
    n = 4'h0;
    for (int i = 0; i < lvrc_pkg::LVRC_CHANS; i++) begin
      n = n + {3'h0, en[i]};
    end
    return n;
  endfunction : chan_count

  // Link receiver: reset clears it all; a window opening or select high
  // drops only a partial word and leaves the word toggle alone.
  assign link_clr_n = link_clr_n_r & ~SELECT_N; // [RULE15] [RULE16]

  lvrc_link_rx u_link (
    .clk_link(HOST_SERIAL_CLOCK),
    .rst_n(RESETN),
    .clr_n(link_clr_n),
    .config_serial_in(CONFIG_SERIAL_IN),
    .word(link_word),
    .word_tgl(word_tgl)
  );

  // Completed-word event brought into the system clock domain.
  lvrc_evt_sync u_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .tgl_in(word_tgl),
    .evt(word_evt)
  );

  // Window events and word qualification.
  assign busy_fall = busy_q_r & ~CONV_BUSY;
  assign busy_rise = ~busy_q_r & CONV_BUSY;
  assign tmr_done = (tmr_r == 22'(STARTUP_CYCLES - 1));
  assign opening = ((state_r == lvrc_pkg::LVRC_ST_BOOT) && tmr_done) ||
                   ((state_r == lvrc_pkg::LVRC_ST_CLOSED) && busy_fall);
  assign in_window = (state_r == lvrc_pkg::LVRC_ST_OPEN);
  assign word_zero = (link_word == lvrc_pkg::LVRC_WORD_ZERO);
  assign take_word = word_evt & in_window & ~word_zero; // [RULE3] [RULE9]
  assign cfg_nxt = take_word ? link_word : RANGE_CFG; // [RULE8] [RULE10]

  // Window sequencer next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lvrc_pkg::LVRC_ST_BOOT: begin
        if (tmr_done) begin
          state_nxt = lvrc_pkg::LVRC_ST_OPEN; // [RULE14]
        end
      end
      lvrc_pkg::LVRC_ST_CLOSED: begin
        if (busy_fall) begin
          state_nxt = lvrc_pkg::LVRC_ST_OPEN; // [RULE14]
        end
      end
      lvrc_pkg::LVRC_ST_OPEN: begin
        if (busy_rise) begin
          state_nxt = lvrc_pkg::LVRC_ST_CLOSED; // [RULE3]
        end
      end
      default: begin
        state_nxt = lvrc_pkg::LVRC_ST_BOOT;
      end
    endcase
  end

  // Sequencer, start-up timer and the link clear pulse.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= lvrc_pkg::LVRC_ST_BOOT;
      tmr_r <= lvrc_pkg::LVRC_TMR_ZERO;
      busy_q_r <= 1'b0;
      link_clr_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      busy_q_r <= CONV_BUSY;
      link_clr_n_r <= ~opening; // [RULE16]
      if ((state_r == lvrc_pkg::LVRC_ST_BOOT) && !tmr_done) begin
        tmr_r <= tmr_r + lvrc_pkg::LVRC_TMR_ONE; // [RULE14]
      end
    end
  end

  // Range register and the settings derived from it.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RANGE_CFG <= lvrc_pkg::LVRC_CFG_RESET; // [RULE1] [RULE2]
      CHAN_EN <= lvrc_pkg::LVRC_EN_RESET;
      CHAN_COUNT <= lvrc_pkg::LVRC_CNT_RESET;
    end else begin
      RANGE_CFG <= cfg_nxt; // [RULE4]
      CHAN_EN <= chan_enables(cfg_nxt); // [RULE5] [RULE6]
      CHAN_COUNT <= chan_count(cfg_nxt); // [RULE5]
    end
  end

  // Status flags.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      WINDOW_OPEN <= 1'b0;
      CFG_LOADED <= 1'b0;
      WORD_KEPT <= 1'b0;
      WORD_REFUSED <= 1'b0;
    end else begin
      WINDOW_OPEN <= (state_nxt == lvrc_pkg::LVRC_ST_OPEN);
      CFG_LOADED <= take_word;
      WORD_KEPT <= word_evt & in_window & word_zero; // [RULE9]
      WORD_REFUSED <= word_evt & ~in_window; // [RULE3]
    end
  end

endmodule : lvrc_loader

// ---- verif/lvrc_loader_assertions.sv ----
// Checker of the range loader's port behaviour.
`timescale 1ns/10ps
module lvrc_loader_chk #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  // Clock, reset and core status
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CONV_BUSY,
  // Watched outputs
  input wire lvrc_pkg::lvrc_cfg_s RANGE_CFG,
  input wire logic [7:0] CHAN_EN,
  input wire logic [3:0] CHAN_COUNT,
  input wire logic WINDOW_OPEN,
  input wire logic CFG_LOADED,
  input wire logic WORD_KEPT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic [31:0] cyc_r;
  logic [7:0] en_exp;
  // Counts cycles since reset release, saturating.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) cyc_r <= 32'h00000000;
    else if (cyc_r != 32'hFFFFFFFF) cyc_r <= cyc_r + 32'h00000001;
  end
  // Enable expected from each channel's code.
  always_comb begin
    for (int i = 0; i < 8; i++) en_exp[i] = |RANGE_CFG.code[i];
  end
  property p_ld; !$stable(RANGE_CFG) |-> CFG_LOADED; endproperty
  a_ld: assert property (p_ld) else $error("cfg moved unflagged");
  property p_nz; CFG_LOADED |-> RANGE_CFG != 24'h000000; endproperty
  a_nz: assert property (p_nz) else $error("zero word loaded");
  property p_kp; WORD_KEPT |-> $stable(RANGE_CFG); endproperty
  a_kp: assert property (p_kp) else $error("kept word changed cfg");
  property p_win; CFG_LOADED |-> WINDOW_OPEN || $past(WINDOW_OPEN); endproperty
  a_win: assert property (p_win) else $error("load off window");
  property p_en; CHAN_EN == en_exp; endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  property p_cnt; CHAN_COUNT == $countones(CHAN_EN); endproperty
  a_cnt: assert property (p_cnt) else $error("count mismatch");
  property p_cls; $rose(CONV_BUSY) |=> !WINDOW_OPEN; endproperty
  a_cls: assert property (p_cls) else $error("window not closed");
  property p_opn; $fell(CONV_BUSY) |-> ##[1:3] WINDOW_OPEN; endproperty
  a_opn: assert property (p_opn) else $error("window not opened");
  property p_st; cyc_r < STARTUP_CYCLES |-> !WINDOW_OPEN; endproperty
  a_st: assert property (p_st) else $error("window too early");
  property p_sto; cyc_r == STARTUP_CYCLES |-> WINDOW_OPEN; endproperty
  a_sto: assert property (p_sto) else $error("window late");
endmodule : lvrc_loader_chk
bind lvrc_loader lvrc_loader_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
  .CLK(CLK), .RESETN(RESETN), .CONV_BUSY(CONV_BUSY), .RANGE_CFG(RANGE_CFG),
  .CHAN_EN(CHAN_EN), .CHAN_COUNT(CHAN_COUNT), .WINDOW_OPEN(WINDOW_OPEN),
  .CFG_LOADED(CFG_LOADED), .WORD_KEPT(WORD_KEPT));

// ---- verif/lvrc_host.sv ----
// Host model that clocks configuration frames onto the serial link.
`timescale 1ns/10ps
module lvrc_host (
  // Serial link towards the loader
  output logic sck,
  output logic dat,
  output logic sel_n
);
  // The link idles deselected with its clock low.
  initial begin
    sck = 1'b0;
    dat = 1'b0;
    sel_n = 1'b1;
  end
  // Sends pairs DDR cycles, MSB first, at a 48 ns period.
  task automatic send(input logic [71:0] bits, input int pairs);
    #5 sel_n = 1'b0;
    for (int k = 0; k < 2 * pairs; k++) begin
      #12 dat = bits[71 - k];
      #12 sck = ~sck;
    end
    #12 dat = ~dat;
    sel_n = 1'b1;
  endtask : send
endmodule : lvrc_host

// ---- verif/test_lvrc_loader.sv ----
// Self-checking testbench of the range configuration loader.
`timescale 1ns/10ps
module test_lvrc_loader;
  localparam int unsigned STARTUP = 20;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic CONV_BUSY = 1'b0;
  wire sck, dat, sel_n;
  lvrc_pkg::lvrc_cfg_s RANGE_CFG;
  logic [7:0] CHAN_EN;
  logic [3:0] CHAN_COUNT;
  logic WINDOW_OPEN, CFG_LOADED, WORD_KEPT, WORD_REFUSED;
  logic [23:0] exp_q[$];
  logic [23:0] w, m;
  int failures = 0, n_compared = 0, n_kept = 0, n_ref = 0, kept_exp = 0;
  int seed = 32'h497EDDCC;
  // The 250 MHz system clock.
  initial forever #2 CLK = ~CLK;
  lvrc_loader #(.STARTUP_CYCLES(STARTUP)) dut (.CLK(CLK), .RESETN(RESETN),
    .HOST_SERIAL_CLOCK(sck), .CONFIG_SERIAL_IN(dat), .SELECT_N(sel_n),
    .CONV_BUSY(CONV_BUSY), .RANGE_CFG(RANGE_CFG), .CHAN_EN(CHAN_EN),
    .CHAN_COUNT(CHAN_COUNT), .WINDOW_OPEN(WINDOW_OPEN),
    .CFG_LOADED(CFG_LOADED), .WORD_KEPT(WORD_KEPT),
    .WORD_REFUSED(WORD_REFUSED));
  lvrc_host host (.sck(sck), .dat(dat), .sel_n(sel_n));
  function automatic logic [7:0] en_of(input logic [23:0] v);
    for (int i = 0; i < 8; i++) en_of[i] = |v[3*i +: 3];
  endfunction : en_of
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Takes the oldest expected word whenever a load is flagged.
  always @(negedge CLK) begin
    if (WORD_KEPT === 1'b1) n_kept++;
    if (WORD_REFUSED === 1'b1) n_ref++;
    if (CFG_LOADED === 1'b1 && exp_q.size() == 0) begin
      check(24'(exp_q.size()), 24'h1);
    end else if (CFG_LOADED === 1'b1) begin
      m = exp_q.pop_front();
      check(RANGE_CFG, m);
      check(24'(CHAN_EN), 24'(en_of(m)));
      check(24'(CHAN_COUNT), 24'($countones(en_of(m))));
    end
  end
  task automatic wait_win();
    for (int i = 0; i < 100 && WINDOW_OPEN !== 1'b1; i++) @(negedge CLK);
    check(24'(WINDOW_OPEN), 24'h1);
    @(posedge CLK);
  endtask : wait_win
  // One conversion, then a frame in or outside the following window.
  task automatic conv(input logic [71:0] b, input int p, input bit open);
    CONV_BUSY <= 1'b1;
    repeat (4) @(posedge CLK);
    CONV_BUSY <= !open;
    repeat (4) @(posedge CLK);
    host.send(b, p);
    repeat (10) @(posedge CLK);
  endtask : conv
  task automatic load(input logic [23:0] v);
    if (v != 24'h000000) exp_q.push_back(v);
    else kept_exp++;
    conv({v, 48'h0}, 12, 1'b1);
  endtask : load
  // Main sequence, run twice with a reset between.
  initial begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    check(RANGE_CFG, 24'hFFFFFF);
    wait_win();
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        w = 24'($random(seed));
        if (i == 0) w[8:0] = 9'h000;
        load(w);
      end
      conv({24'hFFFFFF, 48'h0}, 11, 1'b1);
      load(24'h000000);
      exp_q.push_back(24'h1C7000);
      exp_q.push_back(24'hFFFFFF);
      conv({24'h1C7000, 24'hFFFFFF, 24'hABCDEF}, 29, 1'b1);
      conv({24'h123456, 48'h0}, 12, 1'b0);
      RESETN <= 1'b0;
      CONV_BUSY <= 1'b0;
      repeat (3) @(posedge CLK);
      check(RANGE_CFG, 24'hFFFFFF);
      RESETN <= 1'b1;
      wait_win();
    end
    check(24'(exp_q.size()), 24'h0);
    check(24'(n_kept), 24'(kept_exp));
    check(24'(n_ref), 24'h2);
    end_sim();
  end
  // Cuts a hang short.
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : test_lvrc_loader
